// ==== rtl/adc_dual_seq.sv ====
// Operation
// - Dual select converts A and B each pulse
// - Start from pwm, software or pin
// - Both channels sampled on pulse fall
// - Pulse lasts one plus acquisition value clocks
// - Sampling begins 3 clocks after trigger (100 ns rounded up to whole clocks)
// - First results: A after 4, B after 5
// - Later results every three plus acquisition clocks
// - Done flag set shortly after result update
// - Pair converts continuously without software help
// - Dual select zero converts single channel
//
// The register addresses and the APB register port are this design's own decisions.
module adc_dual_seq
(
  // Clock, reset, enable
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Start sources
  input  wire logic                            pwm_trigger,
  input  wire logic                            external_conversion_start,
  // Converter datapath
  input  wire logic [adc_seq_pkg::DATA_W-1:0]  conv_data_a,
  input  wire logic [adc_seq_pkg::DATA_W-1:0]  conv_data_b,
  output logic                                 sample_hold,
  output logic      [adc_seq_pkg::CH_W-1:0]    chan_pair_sel,
  output logic                                 chan_b_enable,
  // Interrupt
  output logic                                 irq
);
  import adc_seq_pkg::*;

  seq_state_t            state_ff;
  seq_state_t            nxt_state;
  logic [ACQ_W-1:0]      cnt_ff;
  logic [ACQ_W-1:0]      nxt_cnt;
  logic [31:0]           ctrl_ff;
  logic [FLAG_W-1:0]     stat_ff;
  logic [FLAG_W-1:0]     inten_ff;
  logic [DATA_W-1:0]     res_a_ff;
  logic [DATA_W-1:0]     res_b_ff;
  logic [31:0]           prdata_ff;
  logic [RES_B_CYC-1:0]  vld_ff;
  logic [RES_B_CYC-1:0]  dl_ff;
  logic [DATA_W-1:0]     pa_ff [RES_B_CYC];
  logic [DATA_W-1:0]     pb_ff [RES_B_CYC];
  logic [IRQ_CYC-1:0]    irqd_ff;
  logic                  wr;
  logic                  rd_setup;
  logic                  hit;
  logic                  trig;
  logic                  samp;
  logic                  res_a_upd;
  logic                  res_b_upd;
  logic                  res_done;
  logic                  ovr_evt;
  logic [FLAG_W-1:0]     set_evt;
  logic [ACQ_W-1:0]      acq;
  logic                  dual;
  logic                  cont;

  assign acq  = ctrl_ff[CTRL_ACQ_LSB +: ACQ_W];
  assign dual = ctrl_ff[CTRL_DUAL_BIT];
  assign cont = ctrl_ff[CTRL_CONT_BIT];

  // APB decode: zero wait states, error on unmapped offsets
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit      = (paddr == OFS_CTRL) | (paddr == OFS_SWTRG) | (paddr == OFS_STAT) |
                    (paddr == OFS_INTEN) | (paddr == OFS_INTCL) | (paddr == OFS_RESA) |
                    (paddr == OFS_RESB);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = prdata_ff;

  // Start sources; only one index field so pairs always match
  assign trig = (pwm_trigger & ctrl_ff[CTRL_PWM_BIT]) |
                (external_conversion_start & ctrl_ff[CTRL_EXT_BIT]) |
                (wr & (paddr == OFS_SWTRG) & pwdata[SWTRG_BIT]);
  assign ovr_evt       = trig & (state_ff != ST_IDLE);
  assign chan_pair_sel = ctrl_ff[CTRL_CH_LSB +: CH_W];
  assign chan_b_enable = dual;
  assign sample_hold   = (state_ff == ST_SH);
  assign samp          = (state_ff == ST_SH) && (cnt_ff == '0);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (trig) begin
          nxt_state = ST_DELAY;
          nxt_cnt   = ACQ_W'(START_CYC - 2);
        end
      end
      ST_DELAY: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_SH;
          nxt_cnt   = acq;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_SH: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_GAP;
          nxt_cnt   = ACQ_W'(GAP_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_GAP: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else if (cont) begin
          nxt_state = ST_SH;
          nxt_cnt   = acq;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Conversion pipeline: both inputs caught on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_ff <= '0;
      dl_ff  <= '0;
      for (int i = 0; i < RES_B_CYC; i++) begin
        pa_ff[i] <= '0;
        pb_ff[i] <= '0;
      end
    end else if (ce) begin
      vld_ff <= {vld_ff[RES_B_CYC-2:0], samp};
      dl_ff  <= {dl_ff[RES_B_CYC-2:0], samp & dual};
      pa_ff[0] <= samp ? conv_data_a : pa_ff[0];
      pb_ff[0] <= samp ? conv_data_b : pb_ff[0];
      for (int i = 1; i < RES_B_CYC; i++) begin
        pa_ff[i] <= pa_ff[i-1];
        pb_ff[i] <= pb_ff[i-1];
      end
    end
  end

  assign res_a_upd = vld_ff[RES_A_CYC-1];
  assign res_b_upd = vld_ff[RES_B_CYC-1] & dl_ff[RES_B_CYC-1];
  assign res_done  = (res_b_upd) | (res_a_upd & ~dl_ff[RES_A_CYC-1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_a_ff <= '0;
      res_b_ff <= '0;
    end else if (ce) begin
      if (res_a_upd) begin
        res_a_ff <= pa_ff[RES_A_CYC-1];
      end
      if (res_b_upd) begin
        res_b_ff <= pb_ff[RES_B_CYC-1];
      end
    end
  end

  // Flag lags the result write so software never sees stale data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqd_ff <= '0;
    end else if (ce) begin
      irqd_ff <= {irqd_ff[IRQ_CYC-2:0], res_done};
    end
  end

  assign set_evt[STAT_DONE_BIT] = irqd_ff[IRQ_CYC-1];
  assign set_evt[STAT_OVR_BIT]  = ovr_evt;

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else if (ce) begin
      stat_ff <= (stat_ff & ~((wr && paddr == OFS_INTCL) ? pwdata[FLAG_W-1:0] : '0)) | set_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= CTRL_RST;
      inten_ff <= '0;
    end else if (ce && wr) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= pwdata;
      end
      if (paddr == OFS_INTEN) begin
        inten_ff <= pwdata[FLAG_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_ff & inten_ff);
    end
  end

  // Read data is latched in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= ZERO_32;
    end else if (ce && rd_setup) begin
      case (paddr)
        OFS_CTRL:  prdata_ff <= ctrl_ff;
        OFS_STAT:  prdata_ff <= {23'h00_0000, state_ff != ST_IDLE, 6'h00, stat_ff};
        OFS_INTEN: prdata_ff <= {30'h0000_0000, inten_ff};
        OFS_RESA:  prdata_ff <= {20'h0_0000, res_a_ff};
        OFS_RESB:  prdata_ff <= {20'h0_0000, res_b_ff};
        default:   prdata_ff <= ZERO_32;
      endcase
    end
  end

  // Checks assume ce stays high
  localparam int IRQ_D = IRQ_CYC;
  logic [ACQ_W:0] sh_len_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_len_ff <= '0;
    end else if (ce) begin
      sh_len_ff <= sample_hold ? sh_len_ff + 1'b1 : '0;
    end
  end

  property p_trig;
    @(posedge pclk) disable iff (!presetn || !ce)
      (trig && state_ff == ST_IDLE) |=> state_ff == ST_DELAY;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken");

  property p_start;
    @(posedge pclk) disable iff (!presetn || !ce)
      (trig && state_ff == ST_IDLE) |-> !sample_hold[*3] ##1 sample_hold;
  endproperty
  a_start: assert property (p_start) else $error("pulse start late");

  property p_width;
    @(posedge pclk) disable iff (!presetn || !ce)
      $fell(sample_hold) |-> sh_len_ff == $past(acq) + 1'b1;
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");

  property p_cap;
    @(posedge pclk) disable iff (!presetn || !ce)
      samp |=> pa_ff[0] == $past(conv_data_a) && pb_ff[0] == $past(conv_data_b);
  endproperty
  a_cap: assert property (p_cap) else $error("pair not captured together");

  property p_res_a;
    @(posedge pclk) disable iff (!presetn || !ce)
      samp |-> ##4 res_a_upd;
  endproperty
  a_res_a: assert property (p_res_a) else $error("result A timing");

  property p_res_b;
    @(posedge pclk) disable iff (!presetn || !ce)
      (samp && dual) |-> ##5 res_b_upd;
  endproperty
  a_res_b: assert property (p_res_b) else $error("result B timing");

  property p_single;
    @(posedge pclk) disable iff (!presetn || !ce)
      (samp && !dual) |-> ##5 !res_b_upd;
  endproperty
  a_single: assert property (p_single) else $error("B written in single mode");

  // Continuous bit is only looked at in the last gap cycle, so software may stop mid-gap
  property p_period;
    @(posedge pclk) disable iff (!presetn || !ce)
      (samp ##2 cont) |-> (!$past(sample_hold) && !sample_hold) ##1 sample_hold;
  endproperty
  a_period: assert property (p_period) else $error("repeat period wrong");

  property p_flag;
    @(posedge pclk) disable iff (!presetn || !ce)
      res_done |-> !set_evt[STAT_DONE_BIT] ##IRQ_D set_evt[STAT_DONE_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("flag timing");

  c_dual: cover property (@(posedge pclk) disable iff (!presetn) res_b_upd);
  c_cont: cover property (@(posedge pclk) disable iff (!presetn) samp && cont ##3 samp);
  c_ovr:  cover property (@(posedge pclk) disable iff (!presetn) ovr_evt);
  c_irq:  cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule // adc_dual_seq

// ==== rtl/adc_seq_pkg.sv ====
package adc_seq_pkg;
  // Timing: converter clock equals pclk
  localparam int CLK_NS       = 40;
  localparam int START_DLY_NS = 100;
  localparam int START_CYC    = (START_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SH_BASE_CYC  = 1;
  localparam int PERIOD_BASE  = 3;
  localparam int GAP_CYC      = PERIOD_BASE - SH_BASE_CYC;
  localparam int RES_A_CYC    = 4;
  localparam int RES_B_CYC    = 5;
  localparam int IRQ_CYC      = 2;
  // Widths
  localparam int ACQ_W  = 4;
  localparam int DATA_W = 12;
  localparam int CH_W   = 3;
  localparam int ADDR_W = 12;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SWTRG = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_INTEN = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_INTCL = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_RESA  = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_RESB  = 12'h018;
  // Fields
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_PWM_BIT  = 2;
  localparam int CTRL_EXT_BIT  = 3;
  localparam int CTRL_ACQ_LSB  = 8;
  localparam int CTRL_CH_LSB   = 16;
  localparam int SWTRG_BIT     = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_OVR_BIT  = 1;
  localparam int STAT_BUSY_BIT = 8;
  localparam int FLAG_W        = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_32  = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_SH    = 2'b10,
    ST_GAP   = 2'b11
  } seq_state_t;
endpackage

// ==== verification/conv_model.sv ====
module conv_model
(
  // Clock, reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // Converter samples
  output logic      [adc_seq_pkg::DATA_W-1:0]  conv_data_a,
  output logic      [adc_seq_pkg::DATA_W-1:0]  conv_data_b
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_seq_pkg::*;

  // New values every cycle, so a capture one edge off shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_data_a <= 12'h0a5;
      conv_data_b <= 12'h05a;
    end else begin
      conv_data_a <= DATA_W'($urandom);
      conv_data_b <= DATA_W'($urandom);
    end
  end
endmodule // conv_model

// ==== verification/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_seq_pkg::*;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic              pwm_trigger = 0, external_conversion_start = 0, ce = 1;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, err, sample_hold, chan_b_enable, irq;
  logic [CH_W-1:0]   chan_pair_sel;
  logic [DATA_W-1:0] conv_data_a, conv_data_b, cap_a, cap_b;
  int                n_errors = 0, num_checks = 0, n_test = 0, i;

  always #20 pclk = ~pclk;

  // Clock enable dropped only while idle: the sequencer timing checks assume it high
  adc_dual_seq i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_trigger(pwm_trigger), .external_conversion_start(external_conversion_start),
    .conv_data_a(conv_data_a), .conv_data_b(conv_data_b), .sample_hold(sample_hold),
    .chan_pair_sel(chan_pair_sel), .chan_b_enable(chan_b_enable), .irq(irq));
  conv_model i_conv (.pclk(pclk), .presetn(presetn), .conv_data_a(conv_data_a), .conv_data_b(conv_data_b));

  // Last value seen while the pulse is high is the one that must be held
  always_ff @(posedge pclk) begin
    if (sample_hold) begin
      cap_a <= conv_data_a;
      cap_b <= conv_data_b;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_errors++;
      $display("CHECK FAILED t=%0t no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // Edges until the watched output reaches lvl, looked at between edges
  task automatic cnt(input bit sel_irq, input logic lvl, output int k);
    #1;
    k = 0;
    while (((sel_irq ? irq : sample_hold) !== lvl) && k < 200) begin
      @(posedge pclk);
      #1;
      k++;
    end
  endtask

  task automatic pulse(input int src);
    if (src == 0) apb(1, OFS_SWTRG, 32'h0000_0001);
    else begin
      @(posedge pclk);
      if (src == 1) pwm_trigger <= 1;
      else external_conversion_start <= 1;
      @(posedge pclk);
      pwm_trigger <= 0;
      external_conversion_start <= 0;
    end
  endtask

  function automatic int irq_lat(input bit dual);
    return (dual ? RES_B_CYC : RES_A_CYC) + IRQ_CYC + 1;
  endfunction

  task automatic conv(input bit dual, input bit cont, input int src, input int acq, input int pair);
    logic [31:0] ctrl, old_b;
    int k;
    ctrl = {13'h0, 3'(pair), 4'h0, 4'(acq), 4'h0, src == 2, src == 1, cont, dual};
    apb(0, OFS_RESB, 32'h0000_0000);
    old_b = rd;
    apb(1, OFS_INTCL, 32'h0000_0003);
    apb(1, OFS_INTEN, 32'h0000_0001);
    apb(1, OFS_CTRL, ctrl);
    pulse(src);
    cnt(0, 1, k);
    check(k, START_CYC - 1, "start delay");
    check(chan_pair_sel, pair, "pair");
    check(chan_b_enable, dual, "second channel");
    cnt(0, 0, k);
    check(k, acq + SH_BASE_CYC, "pulse width");
    if (cont) begin
      cnt(0, 1, k);
      check(k, GAP_CYC, "repeat gap");
      cnt(0, 0, k);
      check(k, acq + SH_BASE_CYC, "repeat width");
      pulse(1);
      apb(1, OFS_CTRL, ctrl & 32'hffff_fffd);
      repeat (60) @(posedge pclk);
      apb(0, OFS_STAT, 32'h0000_0000);
      check(rd[STAT_OVR_BIT], 1'b1, "overrun");
      apb(1, OFS_INTCL, 32'h0000_0002);
      apb(0, OFS_STAT, 32'h0000_0000);
      check(rd[STAT_OVR_BIT], 1'b0, "overrun cleared");
    end else begin
      cnt(1, 1, k);
      check(k, irq_lat(dual), "flag delay");
    end
    apb(0, OFS_RESA, 32'h0000_0000);
    check(rd, {20'h0, cap_a}, "result a");
    apb(0, OFS_RESB, 32'h0000_0000);
    check(rd, dual ? {20'h0, cap_b} : old_b, "result b");
    n_test++;
    $display("test %0d done: dual %0d cont %0d source %0d", n_test, dual, cont, src);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    n_errors++;
    complete_run;
  end

  initial begin
    void'($urandom(32'h7b84fbdc));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    #1;
    check(sample_hold, 1'b0, "idle pulse");
    check(irq, 1'b0, "idle irq");
    apb(0, OFS_CTRL, 32'h0000_0000);
    check(rd, CTRL_RST, "ctrl reset");
    apb(0, OFS_STAT, 32'h0000_0000);
    check(rd, ZERO_32, "status reset");
    apb(0, 12'h1f0, 32'h0000_0000);
    check(err, 1'b1, "unmapped error");
    check(rd, ZERO_32, "unmapped data");
    // Frozen clock enable drops a write and a software start
    @(posedge pclk);
    ce <= 0;
    apb(1, OFS_CTRL, 32'h0000_0f01);
    apb(1, OFS_SWTRG, 32'h0000_0001);
    ce <= 1;
    repeat (10) @(posedge pclk);
    apb(0, OFS_CTRL, 32'h0000_0000);
    check(rd, CTRL_RST, "frozen ctrl");
    apb(0, OFS_STAT, 32'h0000_0000);
    check(rd, ZERO_32, "frozen start");
    $display("test 0 done: reset, decode and freeze");
    conv(1, 0, 0, 0, 0);
    conv(1, 0, 1, 15, 7);
    conv(0, 0, 2, 3, 5);
    for (i = 0; i < 12; i++) begin
      conv($urandom_range(1, 0), 0, $urandom_range(2, 0), $urandom_range(15, 0), $urandom_range(7, 0));
    end
    conv(1, 1, 1, $urandom_range(15, 0), 3);
    // Reset in mid-pulse leaves nothing pending
    apb(1, OFS_CTRL, 32'h0000_0f01);
    pulse(0);
    cnt(0, 1, i);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    #1;
    check(sample_hold, 1'b0, "reset pulse");
    check(irq, 1'b0, "reset irq");
    repeat (20) @(posedge pclk);
    apb(0, OFS_STAT, 32'h0000_0000);
    check(rd, ZERO_32, "reset status");
    apb(0, OFS_RESA, 32'h0000_0000);
    check(rd, ZERO_32, "reset result");
    $display("test %0d done: reset mid-pulse", n_test);
    // Masked event, then enable and clear
    apb(1, OFS_INTCL, 32'h0000_0003);
    apb(1, OFS_INTEN, 32'h0000_0000);
    apb(1, OFS_CTRL, 32'h0000_0000);
    pulse(0);
    repeat (40) @(posedge pclk);
    check(irq, 1'b0, "masked irq");
    apb(0, OFS_STAT, 32'h0000_0000);
    check(rd[STAT_DONE_BIT], 1'b1, "done sticky");
    apb(1, OFS_INTEN, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check(irq, 1'b1, "enabled irq");
    apb(1, OFS_INTCL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0, "cleared irq");
    $display("test %0d done: interrupt mask and clear", n_test + 1);
    complete_run;
  end
endmodule // tb
